// File: rtl/power_seq_pkg.sv
// Overview of operation
// - five states: on, off, sleep, standby, coin cell
// - no power up below rising undervoltage threshold
// - no register access, no interrupt in coin cell
// - entering on releases processor reset high
// - off on turn-off or thermal; reset low
// - standby control is pin xor polarity bit
// - first power-up copies on settings to standby
// - standby holdoff 0..3 ticks plus three sync ticks
// - qualified standby enters standby, release returns on
// - turn-off with any sleep-keep bit enters sleep
// - sleep keeps interrupt output alive for faults
// - coin cell ignores turn-on, leaves on valid supply
// - depleted coin cell restores every control default
// - level mode: high button turns on, flags irq
// - switch mode: debounced press turns on, flags irq
// - button already high: supply rise turns on
// - sleep to on keeps sleeping rails running
// - switch mode irq both edges, selectable debounce
// - sense follows pin; irq cleared by software/off
// - turn-off by level or long press; optional restart
// - over-temperature forces off, blocks turn-on
// - falling supply drops any state to coin cell
// - debounce counts the 32 kHz timebase ticks
// - rising and falling supply thresholds stay distinct
package power_seq_pkg;

    // ----------------------------------------------------------
    // register map
    // ----------------------------------------------------------
    localparam logic [7:0] REG_POWER_CONTROL = 8'h1b;
    localparam logic [7:0] PCTL_RESET        = 8'h10; // holdoff 01
    localparam int         STBY_INV_BIT      = 6;
    localparam int         HOLDOFF_LSB       = 4;

    // ----------------------------------------------------------
    // timebase
    // ----------------------------------------------------------
    localparam longint CLOCK_HZ    = 100_000_000;
    localparam longint SLOW_HZ     = 32_768;
    localparam int     TICK_CYCLES = int'(CLOCK_HZ / SLOW_HZ);
    localparam int     SYNC_TICKS  = 3;

    // ----------------------------------------------------------
    // debounce and press times in us, converted to ticks
    // ----------------------------------------------------------
    localparam longint DEB_SHORT_US = 31_250;
    localparam longint DEB_MID_US   = 125_000;
    localparam longint DEB_LONG_US  = 750_000;
    localparam longint LONG_PRESS_US = 4_000_000;
    localparam int     CNT_W        = 18;
    localparam logic [CNT_W-1:0] DEB_SHORT =
        CNT_W'(DEB_SHORT_US * SLOW_HZ / 1_000_000);
    localparam logic [CNT_W-1:0] DEB_MID   =
        CNT_W'(DEB_MID_US * SLOW_HZ / 1_000_000);
    localparam logic [CNT_W-1:0] DEB_LONG  =
        CNT_W'(DEB_LONG_US * SLOW_HZ / 1_000_000);
    localparam logic [CNT_W-1:0] LONG_PRESS =
        CNT_W'(LONG_PRESS_US * SLOW_HZ / 1_000_000);

    // ----------------------------------------------------------
    // operating states
    // ----------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF,
        ST_COIN,
        ST_SLEEP,
        ST_STANDBY,
        ST_ON
    } power_state_t;

endpackage

// File: rtl/slow_tick.sv
`timescale 1ns/1ns
// one-cycle pulse once per slow timebase period
module slow_tick #(
    parameter int DIV = power_seq_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // timebase pulse
    output logic      tick
);
    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef struct packed {
        logic [15:0] count;
        logic        tick;
    } tick_state_t;

    tick_state_t s;
    tick_state_t next_s;

    if (DIV < 2 || DIV > 65535)
    begin : g_bad_div
        $error("slow_tick: DIV out of range");
    end

    // wrap counter, pulse on wrap
    always_comb
    begin
        next_s = s;
        next_s.tick = (s.count == 16'(DIV - 1));
        next_s.count = next_s.tick ? 16'h0000 : s.count + 16'h0001;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            s <= '0;
        else
            s <= next_s;
    end

    assign tick = s.tick;

endmodule

// File: rtl/power_state_machine.sv
`timescale 1ns/1ns
// top-level power mode sequencer
module power_state_machine #(
    parameter int NUM_RAILS = 6,
    parameter int TICK_DIV  = power_seq_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rstn,
    // supply and temperature monitors
    input  wire logic                        vin_above_rise,
    input  wire logic                        vin_below_fall,
    input  wire logic                        over_temp,
    input  wire logic                        coin_cell_por_n,
    // board pins
    input  wire logic                        power_button_in,
    input  wire logic                        standby_pin,
    input  wire logic                        fault_event,
    // configuration bits
    input  wire logic                        button_mode_select,
    input  wire logic [1:0]                  button_debounce_sel,
    input  wire logic                        long_press_off_enable,
    input  wire logic                        auto_restart_enable,
    input  wire logic [NUM_RAILS-1:0]        sleep_keep_enable,
    input  wire logic                        button_irq_clear,
    // register port
    input  wire logic [7:0]                  reg_addr,
    input  wire logic                        reg_write,
    input  wire logic [7:0]                  reg_wdata,
    output logic [7:0]                       reg_rdata,
    // status and control outputs
    output logic                             host_reset_out_n,
    output logic                             irq_out_n,
    output logic                             button_irq_flag,
    output logic                             button_sense_bit,
    output logic                             serial_available,
    output logic                             startup_sequence_start,
    output logic                             mirror_standby_settings,
    output power_seq_pkg::power_state_t      power_state
);
    localparam int W = power_seq_pkg::CNT_W;

    if (NUM_RAILS < 1)
    begin : g_bad_rails
        $error("power_state_machine: NUM_RAILS must be at least 1");
    end

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef struct packed {
        power_seq_pkg::power_state_t st;
        logic          btn_s1;
        logic          btn_s2;
        logic          btn_d;
        logic          stb_s1;
        logic          stb_s2;
        logic [W-1:0]  press;
        logic [W-1:0]  release_cnt;
        logic [2:0]    hold;
        logic          stby_q;
        logic [7:0]    pctl;
        logic          irq;
        logic          restart;
        logic          first_done;
        logic          startup;
        logic          mirror;
        logic          rst_n;
        logic          irq_n;
        logic          sense;
        logic [7:0]    rdata;
    } seq_state_t;

    seq_state_t s;
    seq_state_t next_s;
    logic       tick;

    slow_tick #(
        .DIV (TICK_DIV)
    ) u_tick (
        .clock (clock),
        .rstn  (rstn),
        .tick  (tick)
    );

    // ----------------------------------------------------------
    // debounce targets for switch mode
    // ----------------------------------------------------------
    logic [W-1:0] on_deb;
    logic [W-1:0] fall_deb;

    // turn-on and falling-edge debounce by select
    always_comb
    begin
        unique case (button_debounce_sel)
            2'b00:
            begin
                on_deb   = '0;
                fall_deb = power_seq_pkg::DEB_SHORT;
            end
            2'b01:
            begin
                on_deb   = power_seq_pkg::DEB_SHORT;
                fall_deb = power_seq_pkg::DEB_SHORT;
            end
            2'b10:
            begin
                on_deb   = power_seq_pkg::DEB_MID;
                fall_deb = power_seq_pkg::DEB_MID;
            end
            2'b11:
            begin
                on_deb   = power_seq_pkg::DEB_LONG;
                fall_deb = power_seq_pkg::DEB_LONG;
            end
        endcase
    end

    // ----------------------------------------------------------
    // event decode
    // ----------------------------------------------------------
    logic btn;
    logic on_evt;
    logic fall_evt;
    logic rise_evt;
    logic long_evt;
    logic turn_on;
    logic turn_down;
    logic any_keep;
    logic stby_ctrl;
    logic [2:0] hold_target;
    logic irq_set;
    logic powered;

    // event terms look at the second synchroniser flop; the zero-debounce turn-on also looks at its delayed copy btn_d
    always_comb
    begin
        btn = s.btn_s2;
        on_evt = (on_deb == '0) ? (!btn && s.btn_d)
               : (!btn && tick && s.press == on_deb - W'(1));
        fall_evt = !btn && tick && s.press == fall_deb - W'(1);
        rise_evt = btn && tick
                && s.release_cnt == power_seq_pkg::DEB_SHORT - W'(1);
        long_evt = !btn && tick
                && s.press == power_seq_pkg::LONG_PRESS - W'(1);
        any_keep = |sleep_keep_enable;
        // over-temperature and low supply block every turn-on
        turn_on = vin_above_rise && !over_temp && !vin_below_fall
               && ((button_mode_select ? on_evt : btn) || s.restart);
        turn_down = button_mode_select ? (long_press_off_enable && long_evt)
                                       : !btn;
        stby_ctrl = s.stb_s2 ^ s.pctl[power_seq_pkg::STBY_INV_BIT];
        hold_target = {1'b0, s.pctl[power_seq_pkg::HOLDOFF_LSB +: 2]}
                    + 3'(power_seq_pkg::SYNC_TICKS);
        powered = s.st inside {power_seq_pkg::ST_ON, power_seq_pkg::ST_STANDBY,
                               power_seq_pkg::ST_SLEEP};
        irq_set = button_mode_select ? (fall_evt || rise_evt) : 1'b0;
    end

    // ----------------------------------------------------------
    // next state
    // ----------------------------------------------------------
    always_comb
    begin
        next_s = s;
        // two-flop synchronisers for the asynchronous pins
        next_s.btn_s1 = power_button_in;
        next_s.btn_s2 = s.btn_s1;
        next_s.stb_s1 = standby_pin;
        next_s.stb_s2 = s.stb_s1;
        next_s.btn_d  = btn;
        next_s.startup = 1'b0;
        next_s.mirror  = 1'b0;

        // saturating press and release timers in ticks
        if (btn)
            next_s.press = '0;
        else if (tick && s.press != power_seq_pkg::LONG_PRESS)
            next_s.press = s.press + W'(1);
        if (!btn)
            next_s.release_cnt = '0;
        else if (tick && s.release_cnt != power_seq_pkg::DEB_SHORT)
            next_s.release_cnt = s.release_cnt + W'(1);

        // standby holdoff restarts whenever the control level bounces
        if (stby_ctrl == s.stby_q)
            next_s.hold = '0;
        else if (tick)
        begin
            if (s.hold == hold_target - 3'd1 || hold_target == 3'd0)
            begin
                next_s.stby_q = stby_ctrl;
                next_s.hold = '0;
            end
            else
                next_s.hold = s.hold + 3'd1;
        end

        // button flag ahead of the transitions, so that a turn-on into on sets it last
        // and hardware set wins over both the software clear and the clear in off
        if (irq_set)
            next_s.irq = 1'b1;
        else if (button_irq_clear || s.st == power_seq_pkg::ST_OFF)
            next_s.irq = 1'b0;

        // state transitions: supply, then thermal, then button
        unique case (s.st)
            power_seq_pkg::ST_COIN:
            begin
                if (vin_above_rise && !vin_below_fall)
                    next_s.st = power_seq_pkg::ST_OFF;
            end
            power_seq_pkg::ST_OFF:
            begin
                if (vin_below_fall)
                    next_s.st = power_seq_pkg::ST_COIN;
                else if (turn_on)
                begin
                    next_s.st = power_seq_pkg::ST_ON;
                    next_s.startup = 1'b1;
                    next_s.mirror = !s.first_done;
                    next_s.first_done = 1'b1;
                    next_s.restart = 1'b0;
                    if (!button_mode_select)
                        next_s.irq = 1'b1;
                end
            end
            power_seq_pkg::ST_SLEEP:
            begin
                if (vin_below_fall)
                    next_s.st = power_seq_pkg::ST_COIN;
                else if (over_temp)
                    next_s.st = power_seq_pkg::ST_OFF;
                else if (button_mode_select && long_press_off_enable && long_evt)
                    next_s.st = power_seq_pkg::ST_OFF;
                else if (turn_on)
                begin
                    // sleeping rails stay up: no startup sequence
                    next_s.st = power_seq_pkg::ST_ON;
                    if (!button_mode_select)
                        next_s.irq = 1'b1;
                end
            end
            power_seq_pkg::ST_STANDBY, power_seq_pkg::ST_ON:
            begin
                if (vin_below_fall)
                    next_s.st = power_seq_pkg::ST_COIN;
                else if (over_temp)
                    next_s.st = power_seq_pkg::ST_OFF;
                else if (turn_down && any_keep)
                    next_s.st = power_seq_pkg::ST_SLEEP;
                else if (turn_down)
                begin
                    next_s.st = power_seq_pkg::ST_OFF;
                    next_s.restart = auto_restart_enable;
                end
                else if (s.st == power_seq_pkg::ST_ON && s.stby_q)
                    next_s.st = power_seq_pkg::ST_STANDBY;
                else if (s.st == power_seq_pkg::ST_STANDBY && !s.stby_q)
                    next_s.st = power_seq_pkg::ST_ON;
            end
        endcase

        // register write is dead while only the coin cell powers us
        if (reg_write && reg_addr == power_seq_pkg::REG_POWER_CONTROL
            && s.st != power_seq_pkg::ST_COIN)
            next_s.pctl = reg_wdata;
        next_s.rdata = (reg_addr == power_seq_pkg::REG_POWER_CONTROL
                        && s.st != power_seq_pkg::ST_COIN) ? s.pctl : 8'h00;

        // depleted coin cell: state, control register, irq, restart and first-power-up flags back to defaults
        if (!coin_cell_por_n)
        begin
            next_s.st = power_seq_pkg::ST_COIN;
            next_s.pctl = power_seq_pkg::PCTL_RESET;
            next_s.irq = 1'b0;
            next_s.restart = 1'b0;
            next_s.first_done = 1'b0;
        end

        // registered pin outputs follow the next state
        next_s.rst_n = next_s.st inside {power_seq_pkg::ST_ON,
                                         power_seq_pkg::ST_STANDBY};
        next_s.irq_n = !((next_s.irq || fault_event)
                       && next_s.st != power_seq_pkg::ST_OFF
                       && next_s.st != power_seq_pkg::ST_COIN);
        next_s.sense = btn;
    end

    // ----------------------------------------------------------
    // state register
    // ----------------------------------------------------------
    // come up in coin cell: no supply is trusted until it rises
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= '0;
            s.st <= power_seq_pkg::ST_COIN;
            s.pctl <= power_seq_pkg::PCTL_RESET;
            s.irq_n <= 1'b1;
        end
        else
            s <= next_s;
    end

    // output assignments
    assign reg_rdata               = s.rdata;
    assign host_reset_out_n        = s.rst_n;
    assign irq_out_n               = s.irq_n;
    assign button_irq_flag         = s.irq;
    assign button_sense_bit        = s.sense;
    assign serial_available        = s.st != power_seq_pkg::ST_COIN;
    assign startup_sequence_start  = s.startup;
    assign mirror_standby_settings = s.mirror;
    assign power_state             = s.st;

    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence sleep_wake;
        s.st == power_seq_pkg::ST_SLEEP ##1 s.st == power_seq_pkg::ST_ON;
    endsequence

    sequence coin_hold;
        s.st == power_seq_pkg::ST_COIN ##1 s.st == power_seq_pkg::ST_COIN;
    endsequence

    a_fall_to_coin: assert property (s.st != power_seq_pkg::ST_COIN
        && vin_below_fall && coin_cell_por_n |=> s.st == power_seq_pkg::ST_COIN)
        else $error("supply drop did not reach coin cell");
    a_low_vin_off: assert property (s.st == power_seq_pkg::ST_OFF
        && !vin_above_rise |=> s.st != power_seq_pkg::ST_ON)
        else $error("powered up without valid supply");
    a_coin_exit: assert property (s.st == power_seq_pkg::ST_COIN
        |=> s.st inside {power_seq_pkg::ST_COIN, power_seq_pkg::ST_OFF})
        else $error("coin cell left to a powered state");
    a_thermal_off: assert property (powered && over_temp && !vin_below_fall
        && coin_cell_por_n |=> s.st == power_seq_pkg::ST_OFF)
        else $error("over-temperature did not force off");
    a_coin_no_irq: assert property (coin_hold |-> irq_out_n)
        else $error("interrupt driven in coin cell");
    a_reset_release: assert property ($rose(s.st == power_seq_pkg::ST_ON)
        |-> host_reset_out_n)
        else $error("reset held low in on state");
    a_sleep_rails: assert property (sleep_wake |-> !startup_sequence_start)
        else $error("startup sequence rerun after sleep");
    a_standby_in: assert property (s.st == power_seq_pkg::ST_ON && s.stby_q
        && !turn_down && !over_temp && !vin_below_fall && coin_cell_por_n
        |=> s.st == power_seq_pkg::ST_STANDBY)
        else $error("qualified standby not entered");
    a_sense_track: assert property (button_sense_bit
        == $past(power_button_in, 3))
        else $error("sense bit lost the pin level");
    a_coin_no_write: assert property (s.st == power_seq_pkg::ST_COIN
        && coin_cell_por_n |=> $stable(s.pctl))
        else $error("register written in coin cell");

endmodule

// File: bench/board_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------
// board side: power button contact and standby line
// ----------------------------------------------------------
module board_model (
    // clock
    input  wire logic clock,
    // requests from the bench
    input  wire logic press,
    input  wire logic stby,
    // board pins
    output logic      power_button_in = 1'b0,
    output logic      standby_pin     = 1'b0
);
    // pins move just after the edge; both are asynchronous to the device anyway
    always_ff @(posedge clock)
    begin
        power_button_in <= press;
        standby_pin     <= stby;
    end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------
    logic clock = 1'b0, rstn = 1'b0, vin_above_rise = 1'b0, vin_below_fall = 1'b1;
    logic over_temp = 1'b0, fault_event = 1'b0, press = 1'b0, stby = 1'b0;
    logic button_irq_clear = 1'b0, reg_write = 1'b0;
    logic [7:0] reg_addr = 8'h1b, reg_wdata = 8'h00, reg_rdata, d;
    logic [5:0] sleep_keep_enable = 6'h00;
    logic power_button_in, standby_pin, host_reset_out_n, irq_out_n;
    logic button_irq_flag, serial_available, button_sense_bit, startup_sequence_start;
    logic mirror_standby_settings, coin_cell_por_n = 1'b1, button_mode_select = 1'b0;
    int starts = 0;
    int mirrors = 0;
    power_seq_pkg::power_state_t power_state;
    int miscompares = 0;
    int checks_done = 0;
    logic [2:0] note_code[$];
    logic [7:0] note_val[$];
    event result_ev;
    string nm [8] = '{"power_state", "host_reset_out_n", "irq_out_n",
                      "button_irq_flag", "reg_rdata", "serial_available",
                      "button_sense_bit", "startup_and_mirror_counts"};

    // short tick keeps holdoff waits to a few dozen cycles
    power_state_machine #(.NUM_RAILS(6), .TICK_DIV(4)) i_dut (
        .clock(clock), .rstn(rstn), .vin_above_rise(vin_above_rise),
        .vin_below_fall(vin_below_fall), .over_temp(over_temp),
        .coin_cell_por_n(coin_cell_por_n),
        .power_button_in(power_button_in), .standby_pin(standby_pin),
        .fault_event(fault_event), .button_mode_select(button_mode_select),
        .button_debounce_sel(2'b00), .long_press_off_enable(1'b0),
        .auto_restart_enable(1'b0), .sleep_keep_enable(sleep_keep_enable),
        .button_irq_clear(button_irq_clear), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_reset_out_n(host_reset_out_n),
        .irq_out_n(irq_out_n), .button_irq_flag(button_irq_flag),
        .button_sense_bit(button_sense_bit), .serial_available(serial_available),
        .startup_sequence_start(startup_sequence_start),
        .mirror_standby_settings(mirror_standby_settings), .power_state(power_state));

    board_model i_board (.clock(clock), .press(press), .stby(stby),
        .power_button_in(power_button_in), .standby_pin(standby_pin));

    // 100 MHz clock
    initial
    begin
        forever #5 clock = ~clock;
    end

    // one-cycle pulses counted mid-cycle, away from the edge that launches them
    always @(negedge clock)
    begin
        starts  += int'(startup_sequence_start === 1'b1);
        mirrors += int'(mirror_standby_settings === 1'b1);
    end

    // ----------------------------------------------------------
    // checking: oldest note against the output it names
    // ----------------------------------------------------------
    always @(result_ev)
    begin
        logic [2:0] c;
        logic [7:0] e, g;
        c = note_code.pop_front();
        e = note_val.pop_front();
        case (c)
            3'd0:    g = {5'h00, power_state};
            3'd1:    g = {7'h00, host_reset_out_n};
            3'd2:    g = {7'h00, irq_out_n};
            3'd3:    g = {7'h00, button_irq_flag};
            3'd4:    g = reg_rdata;
            3'd5:    g = {7'h00, serial_available};
            3'd6:    g = {7'h00, button_sense_bit};
            default: g = {4'(starts), 4'(mirrors)};
        endcase
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm[c], e, g);
        end
    end

    // notes are taken at the falling edge, where outputs have settled
    task automatic expect_now(input logic [2:0] c, input logic [7:0] v);
        @(negedge clock);
        note_code.push_back(c);
        note_val.push_back(v);
        -> result_ev;
    endtask

    task automatic wait_state(input power_seq_pkg::power_state_t st, input int lim);
        for (int i = 0; i < lim && power_state !== st; i++) @(negedge clock);
        expect_now(3'd0, {5'h00, st});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_addr  <= 8'h1b;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog: the whole sequence needs about 5000 cycles
    initial
    begin
        #500_000;
        miscompares++;
        end_sim();
    end

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial
    begin
        void'($urandom(32'h480ecf5d));
        repeat (9) @(posedge clock);
        expect_now(3'd0, {5'h00, power_seq_pkg::ST_COIN});
        expect_now(3'd1, 8'h00);
        expect_now(3'd2, 8'h01);
        @(posedge clock);
        rstn  <= 1'b1;
        press <= 1'b1;
        wr(8'h1b, 8'h40);
        repeat (20) @(posedge clock);
        wait_state(power_seq_pkg::ST_COIN, 1);
        expect_now(3'd5, 8'h00);
        expect_now(3'd4, 8'h00);
        expect_now(3'd6, 8'h01);
        @(posedge clock);
        press <= 1'b0;
        $display("coin cell test done");
        // the released button must leave the synchroniser before the supply rises
        repeat (4) @(posedge clock);
        vin_below_fall <= 1'b0;
        vin_above_rise <= 1'b1;
        wait_state(power_seq_pkg::ST_OFF, 10);
        expect_now(3'd1, 8'h00);
        expect_now(3'd4, power_seq_pkg::PCTL_RESET);
        d = 8'($urandom()) & 8'h8f;
        wr(8'h1b, d);
        repeat (2) @(posedge clock);
        expect_now(3'd4, d);
        @(posedge clock);
        reg_addr <= 8'h1c;
        repeat (2) @(posedge clock);
        expect_now(3'd4, 8'h00);
        @(posedge clock);
        reg_addr <= 8'h1b;
        press    <= 1'b1;
        wait_state(power_seq_pkg::ST_ON, 10);
        expect_now(3'd1, 8'h01);
        expect_now(3'd3, 8'h01);
        expect_now(3'd2, 8'h00);
        expect_now(3'd7, 8'h11);
        @(posedge clock);
        button_irq_clear <= 1'b1;
        @(posedge clock);
        button_irq_clear <= 1'b0;
        repeat (2) @(posedge clock);
        expect_now(3'd3, 8'h00);
        $display("register and turn-on test done");
        @(posedge clock);
        stby <= 1'b1;
        wait_state(power_seq_pkg::ST_STANDBY, 60);
        expect_now(3'd1, 8'h01);
        @(posedge clock);
        stby <= 1'b0;
        wait_state(power_seq_pkg::ST_ON, 60);
        wr(8'h1b, 8'h70); // inverted polarity, longest holdoff
        wait_state(power_seq_pkg::ST_STANDBY, 80);
        wr(8'h1b, 8'h00);
        wait_state(power_seq_pkg::ST_ON, 60);
        $display("standby test done");
        @(posedge clock);
        sleep_keep_enable <= 6'($urandom_range(1, 63));
        press <= 1'b0;
        wait_state(power_seq_pkg::ST_SLEEP, 10);
        expect_now(3'd1, 8'h00);
        expect_now(3'd6, 8'h00);
        @(posedge clock);
        fault_event <= 1'b1;
        repeat (3) @(posedge clock);
        expect_now(3'd2, 8'h00);
        @(posedge clock);
        fault_event <= 1'b0;
        press       <= 1'b1;
        wait_state(power_seq_pkg::ST_ON, 10);
        @(posedge clock);
        sleep_keep_enable <= 6'h00;
        press <= 1'b0;
        wait_state(power_seq_pkg::ST_OFF, 10);
        expect_now(3'd1, 8'h00);
        $display("sleep and turn-off test done");
        @(posedge clock);
        press <= 1'b1;
        wait_state(power_seq_pkg::ST_ON, 10);
        @(posedge clock);
        over_temp <= 1'b1;
        wait_state(power_seq_pkg::ST_OFF, 10);
        repeat (20) @(posedge clock);
        wait_state(power_seq_pkg::ST_OFF, 1);
        @(posedge clock);
        over_temp <= 1'b0;
        wait_state(power_seq_pkg::ST_ON, 10);
        $display("thermal test done");
        @(posedge clock);
        vin_below_fall <= 1'b1;
        vin_above_rise <= 1'b0;
        wait_state(power_seq_pkg::ST_COIN, 10);
        expect_now(3'd5, 8'h00);
        expect_now(3'd2, 8'h01);
        expect_now(3'd1, 8'h00);
        $display("undervoltage test done");
        @(posedge clock);
        coin_cell_por_n <= 1'b0;
        @(posedge clock);
        coin_cell_por_n <= 1'b1;
        vin_below_fall  <= 1'b0;
        vin_above_rise  <= 1'b1;
        // button still high: the supply rise alone is the turn-on
        wait_state(power_seq_pkg::ST_ON, 10);
        expect_now(3'd4, power_seq_pkg::PCTL_RESET);
        expect_now(3'd7, 8'h42);
        $display("coin cell reset test done");
        @(posedge clock);
        over_temp <= 1'b1;
        wait_state(power_seq_pkg::ST_OFF, 10);
        @(posedge clock);
        over_temp          <= 1'b0;
        button_mode_select <= 1'b1;
        repeat (6) @(posedge clock);
        wait_state(power_seq_pkg::ST_OFF, 1);
        @(posedge clock);
        press <= 1'b0;
        wait_state(power_seq_pkg::ST_ON, 10);
        expect_now(3'd3, 8'h00);
        // falling-edge flag needs 1024 ticks of four cycles each
        repeat (4200) @(posedge clock);
        expect_now(3'd3, 8'h01);
        expect_now(3'd7, 8'h52);
        $display("switch mode test done");
        end_sim();
    end
endmodule
